/* rtl/ads_pkg.sv */
// constants, states and carrier types of the waveform sequencer converter controller
package ads_pkg;
   // ==========================================================
   // timing
   localparam int CLK_HZ = 100_000_000;
   localparam int TMR_HZ = 10_000_000;
   localparam int PRESCALE = CLK_HZ / TMR_HZ;
   localparam logic [31:0] MIN_TRIG_DIV = 32'h0000_0028;
   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [4:0] IDX_OUT_OFF = 5'h0E;
   localparam logic [4:0] IDX_OUT_ON = 5'h0F;
   localparam logic [4:0] IDX_CTRL = 5'h10;
   localparam logic [4:0] IDX_IRQ_EN = 5'h11;
   localparam logic [4:0] IDX_SW_TRIG = 5'h12;
   localparam logic [4:0] IDX_DAC_RST = 5'h13;
   localparam logic [4:0] IDX_MEM_ADDR = 5'h14;
   localparam logic [4:0] IDX_MEM_DATA = 5'h15;
   localparam logic [4:0] IDX_TRIG_DIV = 5'h16;
   localparam logic [4:0] IDX_TMR0_DIV = 5'h17;
   localparam logic [4:0] IDX_IRQ_STAT = 5'h18;
   localparam logic [4:0] IDX_REGION = 5'h19;
   localparam logic [4:0] IDX_REGION_SEL = 5'h1A;
   localparam logic [4:0] IDX_STATUS = 5'h1B;
   // ==========================================================
   // fields and reset values
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;
   localparam int CTRL_PAUSE_BIT = 2;
   localparam int CTRL_REF_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int IRQ_CONV_BIT = 0;
   localparam int IRQ_TMR0_BIT = 1;
   localparam int IRQ_TRIG_BIT = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam int EXT_START = 0;
   localparam int EXT_STOP = 1;
   localparam int EXT_PAUSE = 2;
   localparam logic [31:0] TRIG_DIV_RESET = 32'h0000_0028;
   localparam logic [15:0] TMR0_DIV_RESET = 16'hFFFF;
   localparam logic [2:0] LAST_CH = 3'h7;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      ADS_IDLE = 2'b00,
      ADS_FETCH = 2'b01,
      ADS_PUT = 2'b11,
      ADS_CONV = 2'b10
   } ads_state_t;
   typedef struct packed {
      logic [11:0] data;
      logic [2:0] chan;
      logic load;
      logic conv;
      logic reset;
   } ads_dac_port_t;
endpackage

/* rtl/ads_top.sv */
// waveform sequencer, timers, interrupt logic and register slave of the converter board
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// Operation
// - value from waveform memory or host write
// - shared 12-bit data, 3-bit channel, one load strobe
// - 16-bit countdown timer drives header pin
// - 32-bit divider triggers the sequencer
// - both timers count 10MHz, both interrupt
// - eight sequential loads, divisor at least 40
// - 64K words split into per-channel regions
// - eight waveforms of 12-bit samples
// - simultaneous update by software or sequencer
// - start, stop, pause by software or pins
// - start strobe and stopped status on header
// - reference in standby after power-up
// - control bit 6 enables, clearing zeroes outputs
// - interrupt on conversion, timer falling edge or sequencer trigger
// - 32-entry block decoded against base address
// - write to 12h triggers all channels
module ads_top #(
   parameter int MEM_AW = 16,
   parameter logic [4:0] BASE_SEL = 5'h16
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // interrupt
   output logic irq,
   // converter
   output ads_pkg::ads_dac_port_t dac_port,
   output logic ref_enable,
   // control header
   input wire logic ext_start,
   input wire logic ext_stop,
   input wire logic ext_pause,
   output logic tmr0_out,
   output logic conv_mon,
   output logic stopped_mon
);
   localparam int PS_W = $clog2(ads_pkg::PRESCALE);
   localparam int DEPTH = 2 ** MEM_AW;

   if (MEM_AW < 4 || MEM_AW > 16) begin : g_chk
      $error("MEM_AW must lie between 4 and 16");
   end

   // ==========================================================
   // bus decode
   logic ack_reg, ack_next, hit, wr_go, rd_go;
   logic [4:0] idx;
   logic [31:0] wmask, wd;
   assign idx = avs_address[4:0];
   assign hit = avs_address[9:5] == BASE_SEL;
   assign ack_next = (avs_read | avs_write) & ~ack_reg;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign wr_go = avs_write & ack_reg & hit;
   assign rd_go = avs_read & ack_reg & hit;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wd = avs_writedata & wmask;

   // ==========================================================
   // pin synchronisers
   logic [2:0] ext_s1_reg, ext_s2_reg, ext_prev_reg;
   logic ext_start_rise, ext_stop_rise;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_s1_reg <= 3'h0;
         ext_s2_reg <= 3'h0;
         ext_prev_reg <= 3'h0;
      end else begin
         ext_s1_reg <= {ext_pause, ext_stop, ext_start};
         ext_s2_reg <= ext_s1_reg;
         ext_prev_reg <= ext_s2_reg;
      end
   end
   assign ext_start_rise = ext_s2_reg[ads_pkg::EXT_START] & ~ext_prev_reg[ads_pkg::EXT_START];
   assign ext_stop_rise = ext_s2_reg[ads_pkg::EXT_STOP] & ~ext_prev_reg[ads_pkg::EXT_STOP];

   // ==========================================================
   // timers
   logic [PS_W-1:0] ps_reg, ps_next;
   logic [15:0] t0_cnt_reg, t0_cnt_next;
   logic [31:0] tr_cnt_reg, tr_cnt_next, tr_load;
   logic t0_out_reg, t0_out_next;
   logic trig_reg, trig_next;
   logic tick;
   logic [15:0] tmr0_div_reg;
   logic [31:0] trig_div_reg;
   assign tick = ps_reg == PS_W'(ads_pkg::PRESCALE - 1);
   always_comb begin
      ps_next = tick ? '0 : ps_reg + 1'b1;
      t0_cnt_next = t0_cnt_reg;
      tr_cnt_next = tr_cnt_reg;
      // divisors below the sequence time are raised to the minimum
      tr_load = (trig_div_reg < ads_pkg::MIN_TRIG_DIV) ? ads_pkg::MIN_TRIG_DIV : trig_div_reg;
      trig_next = tick && tr_cnt_reg <= 32'h0000_0001;
      if (tick) begin
         t0_cnt_next = (t0_cnt_reg <= 16'h0001) ? tmr0_div_reg : t0_cnt_reg - 16'h0001;
         tr_cnt_next = (tr_cnt_reg <= 32'h0000_0001) ? tr_load : tr_cnt_reg - 32'h0000_0001;
      end
      // a new divisor restarts the count at once, not after the old one runs out
      if (wr_go && idx == ads_pkg::IDX_TMR0_DIV) begin
         t0_cnt_next = (tmr0_div_reg & ~wmask[15:0]) | wd[15:0];
      end
      t0_out_next = t0_cnt_reg > {1'b0, tmr0_div_reg[15:1]};
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ps_reg <= '0;
         t0_cnt_reg <= ads_pkg::TMR0_DIV_RESET;
         tr_cnt_reg <= ads_pkg::TRIG_DIV_RESET;
         t0_out_reg <= 1'b0;
         trig_reg <= 1'b0;
      end else begin
         ps_reg <= ps_next;
         t0_cnt_reg <= t0_cnt_next;
         tr_cnt_reg <= tr_cnt_next;
         t0_out_reg <= t0_out_next;
         trig_reg <= trig_next;
      end
   end
   assign tmr0_out = t0_out_reg;

   // ==========================================================
   // host registers
   logic [7:0] ctrl_reg, ctrl_next;
   logic [2:0] irq_en_reg, irq_en_next, irq_stat_reg, irq_stat_next, irq_set;
   logic [MEM_AW-1:0] mem_addr_reg, mem_addr_next;
   logic [31:0] trig_div_next, rdata_reg, rdata_next;
   logic [15:0] tmr0_div_next;
   logic [2:0] region_sel_reg, region_sel_next;
   logic [7:0] lsb_reg [8], lsb_next [8];
   logic mem_we, region_wr, stop_evt, active, busy;
   ads_pkg::ads_state_t state_reg, state_next;
   logic [2:0] ch_reg, ch_next;
   logic [MEM_AW-1:0] ptr_reg [8], start_reg [8], last_reg [8];
   ads_pkg::ads_dac_port_t dac_reg, dac_next;

   always_comb begin
      ctrl_next = ctrl_reg;
      irq_en_next = irq_en_reg;
      mem_addr_next = mem_addr_reg;
      trig_div_next = trig_div_reg;
      tmr0_div_next = tmr0_div_reg;
      region_sel_next = region_sel_reg;
      lsb_next = lsb_reg;
      mem_we = 1'b0;
      region_wr = 1'b0;
      rdata_next = rdata_reg;
      if (wr_go) begin
         case (idx)
            ads_pkg::IDX_CTRL: ctrl_next = (ctrl_reg & ~wmask[7:0]) | wd[7:0];
            ads_pkg::IDX_IRQ_EN: irq_en_next = (irq_en_reg & ~wmask[2:0]) | wd[2:0];
            ads_pkg::IDX_MEM_ADDR: mem_addr_next = wd[MEM_AW-1:0];
            ads_pkg::IDX_MEM_DATA: begin
               mem_we = 1'b1;
               mem_addr_next = mem_addr_reg + 1'b1;
            end
            ads_pkg::IDX_TRIG_DIV: trig_div_next = (trig_div_reg & ~wmask) | wd;
            ads_pkg::IDX_TMR0_DIV: tmr0_div_next = (tmr0_div_reg & ~wmask[15:0]) | wd[15:0];
            ads_pkg::IDX_REGION: region_wr = 1'b1;
            ads_pkg::IDX_REGION_SEL: region_sel_next = wd[2:0];
            default: if (idx[4] == 1'b0 && idx[0] == 1'b0 && avs_byteenable[0]) lsb_next[idx[3:1]] = wd[7:0];
         endcase
      end
      // external pins act as edges on the run bit, pause is a level; stop wins
      if (ext_start_rise || ext_stop_rise) ctrl_next[ads_pkg::CTRL_RUN_BIT] = ~ext_stop_rise;
      if (rd_go && idx == ads_pkg::IDX_OUT_OFF) ctrl_next[ads_pkg::CTRL_REF_BIT] = 1'b0;
      if (rd_go && idx == ads_pkg::IDX_OUT_ON) ctrl_next[ads_pkg::CTRL_REF_BIT] = 1'b1;
      // status bits: set wins over a write-one clear
      irq_set = {trig_reg, t0_out_reg & ~t0_out_next, dac_reg.conv};
      irq_stat_next = (wr_go && idx == ads_pkg::IDX_IRQ_STAT) ? irq_stat_reg & ~wd[2:0] : irq_stat_reg;
      irq_stat_next = irq_stat_next | irq_set;
      if (ack_next && avs_read) begin
         // foreign addresses fall through to the zero default
         case (hit ? idx : 5'h00)
            ads_pkg::IDX_CTRL: rdata_next = {24'h00_0000, ctrl_reg};
            ads_pkg::IDX_IRQ_EN: rdata_next = {29'h0000_0000, irq_en_reg};
            ads_pkg::IDX_MEM_ADDR: rdata_next = 32'(mem_addr_reg);
            ads_pkg::IDX_TRIG_DIV: rdata_next = trig_div_reg;
            ads_pkg::IDX_TMR0_DIV: rdata_next = {16'h0000, tmr0_div_reg};
            ads_pkg::IDX_IRQ_STAT: rdata_next = {29'h0000_0000, irq_stat_reg};
            ads_pkg::IDX_REGION: rdata_next = {16'(last_reg[region_sel_reg]), 16'(start_reg[region_sel_reg])};
            ads_pkg::IDX_REGION_SEL: rdata_next = {29'h0000_0000, region_sel_reg};
            ads_pkg::IDX_STATUS: rdata_next = {25'h000_0000, state_reg, ch_reg, busy, ~ctrl_reg[1]};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_reg <= 1'b0;
         ctrl_reg <= ads_pkg::CTRL_RESET;
         irq_en_reg <= ads_pkg::IRQ_RESET;
         irq_stat_reg <= ads_pkg::IRQ_RESET;
         mem_addr_reg <= '0;
         trig_div_reg <= ads_pkg::TRIG_DIV_RESET;
         tmr0_div_reg <= ads_pkg::TMR0_DIV_RESET;
         region_sel_reg <= 3'h0;
         rdata_reg <= 32'h0000_0000;
         lsb_reg <= '{default: 8'h00};
      end else begin
         ack_reg <= ack_next;
         ctrl_reg <= ctrl_next;
         irq_en_reg <= irq_en_next;
         irq_stat_reg <= irq_stat_next;
         mem_addr_reg <= mem_addr_next;
         trig_div_reg <= trig_div_next;
         tmr0_div_reg <= tmr0_div_next;
         region_sel_reg <= region_sel_next;
         rdata_reg <= rdata_next;
         lsb_reg <= lsb_next;
      end
   end
   assign avs_readdata = rdata_reg;
   assign irq = |(irq_stat_reg & irq_en_reg);

   // ==========================================================
   // waveform memory
   logic [11:0] wave_mem [DEPTH];
   logic [11:0] mem_q_reg;
   always_ff @(posedge clk) begin
      if (mem_we) begin
         wave_mem[mem_addr_reg] <= avs_writedata[11:0];
      end
      mem_q_reg <= wave_mem[ptr_reg[ch_reg]];
   end

   // ==========================================================
   // per-channel regions and pointers
   assign stop_evt = ctrl_reg[ads_pkg::CTRL_RUN_BIT] & ~ctrl_next[ads_pkg::CTRL_RUN_BIT];
   for (genvar c = 0; c < 8; c++) begin : g_ch
      localparam logic [MEM_AW-1:0] REG_START = MEM_AW'(c) << (MEM_AW - 3);
      localparam logic [MEM_AW-1:0] REG_LAST = REG_START | {3'h0, {(MEM_AW - 3){1'b1}}};
      logic [MEM_AW-1:0] ptr_next, start_next, last_next;
      always_comb begin
         ptr_next = ptr_reg[c];
         start_next = start_reg[c];
         last_next = last_reg[c];
         if (region_wr && region_sel_reg == 3'(c)) begin
            start_next = avs_writedata[MEM_AW-1:0];
            last_next = avs_writedata[16+MEM_AW-1:16];
            ptr_next = avs_writedata[MEM_AW-1:0];
         end else if (stop_evt) begin
            ptr_next = start_reg[c];
         end else if (state_reg == ads_pkg::ADS_PUT && ch_reg == 3'(c)) begin
            ptr_next = (ptr_reg[c] == last_reg[c]) ? start_reg[c] : ptr_reg[c] + 1'b1;
         end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            ptr_reg[c] <= REG_START;
            start_reg[c] <= REG_START;
            last_reg[c] <= REG_LAST;
         end else begin
            ptr_reg[c] <= ptr_next;
            start_reg[c] <= start_next;
            last_reg[c] <= last_next;
         end
      end
   end

   // ==========================================================
   // sequencer and converter port
   assign active = ctrl_reg[ads_pkg::CTRL_SRC_BIT] & ctrl_reg[ads_pkg::CTRL_RUN_BIT] &
                   ~ctrl_reg[ads_pkg::CTRL_PAUSE_BIT] & ~ext_s2_reg[ads_pkg::EXT_PAUSE];
   assign busy = state_reg != ads_pkg::ADS_IDLE;
   always_comb begin
      state_next = state_reg;
      ch_next = ch_reg;
      dac_next = dac_reg;
      dac_next.load = 1'b0;
      dac_next.conv = 1'b0;
      dac_next.reset = 1'b0;
      case (state_reg)
         ads_pkg::ADS_IDLE: begin
            if (trig_reg && active) begin
               state_next = ads_pkg::ADS_FETCH;
               ch_next = 3'h0;
            end
         end
         ads_pkg::ADS_FETCH: state_next = ads_pkg::ADS_PUT;
         ads_pkg::ADS_PUT: begin
            dac_next.data = mem_q_reg;
            dac_next.chan = ch_reg;
            dac_next.load = 1'b1;
            if (ch_reg == ads_pkg::LAST_CH) begin
               state_next = ads_pkg::ADS_CONV;
            end else begin
               ch_next = ch_reg + 3'h1;
               state_next = ads_pkg::ADS_FETCH;
            end
         end
         ads_pkg::ADS_CONV: begin
            dac_next.conv = 1'b1;
            state_next = ads_pkg::ADS_IDLE;
         end
         default: state_next = ads_pkg::ADS_IDLE;
      endcase
      if (wr_go && idx[4] == 1'b0 && idx[0] && !ctrl_reg[ads_pkg::CTRL_SRC_BIT]) begin
         dac_next.data = {avs_writedata[3:0], lsb_reg[idx[3:1]]};
         dac_next.chan = idx[3:1];
         dac_next.load = 1'b1;
      end
      if (wr_go && idx == ads_pkg::IDX_SW_TRIG) dac_next.conv = 1'b1;
      if (wr_go && idx == ads_pkg::IDX_DAC_RST) dac_next.reset = 1'b1;
      // follow the reference bit as it will stand when the data appear
      if (!ctrl_next[ads_pkg::CTRL_REF_BIT]) dac_next.data = 12'h000;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ads_pkg::ADS_IDLE;
         ch_reg <= 3'h0;
         dac_reg <= '0;
      end else begin
         state_reg <= state_next;
         ch_reg <= ch_next;
         dac_reg <= dac_next;
      end
   end
   assign dac_port = dac_reg;
   assign ref_enable = ctrl_reg[ads_pkg::CTRL_REF_BIT];
   assign conv_mon = dac_reg.conv;
   assign stopped_mon = ~ctrl_reg[ads_pkg::CTRL_RUN_BIT];
endmodule

/* sim/ads_conv_model.sv */
// behavioural model of the octal converter on the far side of the data port
`timescale 1ns/1ps
module ads_conv_model (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // converter port
   input wire ads_pkg::ads_dac_port_t dac_port,
   input wire logic ref_enable,
   // output codes
   output logic [7:0][11:0] vout
);
   logic [7:0][11:0] hold;
   logic [7:0][11:0] live;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hold <= '0;
         live <= '0;
      end else if (dac_port.reset) begin
         hold <= '0;
         live <= '0;
      end else begin
         if (dac_port.load) hold[dac_port.chan] <= dac_port.data;
         if (dac_port.conv) live <= hold;
      end
   end
   // reference in standby pulls every output to zero
   assign vout = ref_enable ? live : '0;
endmodule

/* sim/ads_chk.sv */
// port checker of the converter controller
`timescale 1ns/1ps
module ads_chk #(
   parameter logic [4:0] BASE_SEL = 5'h16
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register bus
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // converter and header
   input wire logic irq,
   input wire ads_pkg::ads_dac_port_t dac_port,
   input wire logic ref_enable,
   input wire logic ext_start,
   input wire logic ext_stop,
   input wire logic ext_pause,
   input wire logic tmr0_out,
   input wire logic conv_mon,
   input wire logic stopped_mon
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========
   // assertions
   a_one_wait: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   a_foreign_zero: assert property (avs_read && !avs_waitrequest && avs_address[9:5] != BASE_SEL |-> avs_readdata == 32'h0)
      else $error("foreign address read not zero");
   a_load_pulse: assert property (dac_port.load |=> !dac_port.load)
      else $error("load strobe longer than one cycle");
   a_load_alone: assert property (dac_port.load |-> !dac_port.conv)
      else $error("load and conversion together");
   a_chan_step: assert property (dac_port.load && !stopped_mon && dac_port.chan != 3'h7
      |-> ##2 dac_port.load && dac_port.chan == $past(dac_port.chan, 2) + 3'h1)
      else $error("sequencer channel order broken");
   a_conv_last: assert property (dac_port.load && !stopped_mon && dac_port.chan == 3'h7 |=> dac_port.conv)
      else $error("no conversion after last channel");
   a_conv_gap: assert property (dac_port.conv && !stopped_mon |=> (!dac_port.conv) [*8])
      else $error("sequencer conversions too close");
   a_mon_copy: assert property (conv_mon == dac_port.conv)
      else $error("conversion monitor differs");
   a_tmr_high: assert property ($rose(tmr0_out) |=> tmr0_out [*8])
      else $error("timer high phase too short");
   a_tmr_low: assert property ($fell(tmr0_out) |=> (!tmr0_out) [*8])
      else $error("timer low phase too short");
   a_zero_data: assert property (dac_port.load && !ref_enable |-> dac_port.data == 12'h000)
      else $error("data not zero in standby");
   c_seq_conv: cover property (dac_port.conv && !stopped_mon);
   c_sw_load: cover property (dac_port.load && stopped_mon);
   c_irq_rise: cover property ($rose(irq));
endmodule
bind ads_top ads_chk #(.BASE_SEL(BASE_SEL)) u_chk (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .dac_port(dac_port),
   .ref_enable(ref_enable), .ext_start(ext_start), .ext_stop(ext_stop), .ext_pause(ext_pause),
   .tmr0_out(tmr0_out), .conv_mon(conv_mon), .stopped_mon(stopped_mon));

/* sim/ads_top_tb.sv */
// self-checking bench of the converter controller
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module ads_top_tb;
   localparam logic [4:0] BASE = 5'h16;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, irq, ref_enable, tmr0_out, conv_mon, stopped_mon;
   logic ext_start = 1'b0;
   logic ext_stop = 1'b0;
   logic ext_pause = 1'b0;
   ads_pkg::ads_dac_port_t dac_port;
   logic [7:0][11:0] vout;
   logic [7:0][11:0] exp_v;
   logic [11:0] mem [64];
   logic [11:0] v;
   logic t_prev;
   logic [31:0] lfsr = 32'h0001_5706;
   logic [31:0] q;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   int prev = 0;
   int n;
   always #5 clk = ~clk;
   ads_top #(.MEM_AW(6), .BASE_SEL(BASE)) dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .dac_port(dac_port),
      .ref_enable(ref_enable), .ext_start(ext_start), .ext_stop(ext_stop), .ext_pause(ext_pause),
      .tmr0_out(tmr0_out), .conv_mon(conv_mon), .stopped_mon(stopped_mon));
   ads_conv_model conv (.clk(clk), .sys_rst(sys_rst), .dac_port(dac_port), .ref_enable(ref_enable), .vout(vout));
   // ==========
   // helpers
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         fail_count++;
         stop_test();
      end
   end
   function automatic logic [11:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[11:0];
   endfunction
   function automatic logic [11:0] seq_exp(input int c, input int idx);
      return mem[c * 8 + idx];
   endfunction
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] idx, input logic [31:0] d, input logic [4:0] base);
      @(posedge clk);
      avs_address <= {base, idx};
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wr(input logic [4:0] i, input logic [31:0] d);
      bus(1'b1, i, d, BASE);
   endtask
   task automatic rd(input logic [4:0] i);
      bus(1'b0, i, 32'h0, BASE);
   endtask
   task automatic seq_check(input int idx);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (conv_mon !== 1'b1 && k < 1000);
      @(negedge clk);
      for (int c = 0; c < 8; c++) `CHK(vout[c], seq_exp(c, idx))
   endtask
   // ==========
   // scenarios
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      `CHK(stopped_mon, 1'b1)
      `CHK(ref_enable, 1'b0)
      bus(1'b1, 5'h10, 32'h0000_0043, 5'h00);
      rd(5'h10);
      `CHK(q, 32'h0)
      bus(1'b0, 5'h16, 32'h0, 5'h00);
      `CHK(q, 32'h0)
      rd(5'h16);
      `CHK(q, 32'h0000_0028)
      rd(5'h17);
      `CHK(q, 32'h0000_FFFF)
      wr(5'h10, 32'h0000_0040);
      for (int c = 0; c < 8; c++) begin
         v = rnd();
         exp_v[c] = v;
         wr(5'(2 * c), {24'h0, v[7:0]});
         wr(5'(2 * c + 1), {28'h0, v[11:8]});
      end
      `CHK(vout[7], 12'h000)
      wr(5'h12, 32'h0);
      @(negedge clk);
      for (int c = 0; c < 8; c++) `CHK(vout[c], exp_v[c])
      `CHK(irq, 1'b0)
      wr(5'h11, 32'h0000_0001);
      `CHK(irq, 1'b1)
      wr(5'h18, 32'h0000_0001);
      `CHK(irq, 1'b0)
      rd(5'h0E);
      `CHK(ref_enable, 1'b0)
      `CHK(vout[0], 12'h000)
      wr(5'h01, 32'h0000_000F);
      rd(5'h0F);
      `CHK(vout[0], exp_v[0])
      wr(5'h17, 32'h0000_0004);
      repeat (50) @(negedge clk);
      n = 0;
      repeat (400) begin
         t_prev = tmr0_out;
         @(negedge clk);
         if (tmr0_out === 1'b1 && t_prev === 1'b0) n++;
      end
      `CHK(n, 10)
      rd(5'h18);
      `CHK(q[1], 1'b1)
      wr(5'h14, 32'h0);
      for (int i = 0; i < 64; i++) begin
         v = rnd();
         mem[i] = v;
         wr(5'h15, {20'h0, v});
      end
      wr(5'h16, 32'h0000_0010);
      wr(5'h10, 32'h0000_0043);
      for (int j = 0; j < 9; j++) begin
         seq_check(j % 8);
         if (j > 0) `CHK(cycles - prev, 400)
         prev = cycles;
      end
      @(posedge clk);
      ext_pause <= 1'b1;
      n = 0;
      repeat (900) begin
         @(negedge clk);
         if (conv_mon === 1'b1) n++;
      end
      `CHK(n, 0)
      @(posedge clk);
      ext_pause <= 1'b0;
      seq_check(1);
      @(posedge clk);
      ext_stop <= 1'b1;
      repeat (3) @(posedge clk);
      ext_stop <= 1'b0;
      repeat (4) @(negedge clk);
      `CHK(stopped_mon, 1'b1)
      @(posedge clk);
      ext_start <= 1'b1;
      repeat (3) @(posedge clk);
      ext_start <= 1'b0;
      seq_check(0);
      `CHK(stopped_mon, 1'b0)
      wr(5'h13, 32'h0);
      `CHK(vout[0], 12'h000)
      stop_test();
   end
endmodule
